// *** cpp_analog_model.sv ***
// analog front end and bus decay model facing the charger power path
`timescale 1ns/1ps
`default_nettype none
module cpp_analog_model (
  input wire logic ref_clk_i,
  input wire logic [15:0] bat_mv_i,
  input wire logic [15:0] adp_mv_i,
  input wire logic [15:0] floor_i,
  input wire logic learn_mode_i,
  output logic bat_above_2v4_o,
  output logic adp_above_3v2_o,
  output logic bias_above_3v8_o,
  output logic bat_above_5v8_o,
  output logic bat_below_floor_o,
  output logic sys_at_bat_o
);
  logic [7:0] decay_q;
  assign bat_above_2v4_o = bat_mv_i > 16'h0960;
  assign adp_above_3v2_o = adp_mv_i > 16'h0C80;
  // bias comes from the adapter side
  assign bias_above_3v8_o = adp_mv_i > 16'h0ED8;
  assign bat_above_5v8_o = bat_mv_i > 16'h16A8;
  assign bat_below_floor_o = bat_mv_i < floor_i;
  // bus needs time to sag to battery level after the converter stops
  always_ff @(posedge ref_clk_i) begin
    if (!learn_mode_i) decay_q <= 8'h00;
    else if (decay_q != 8'h14) decay_q <= decay_q + 8'h01;
  end
  assign sys_at_bat_o = decay_q == 8'h14;
endmodule // cpp_analog_model
`default_nettype wire

// *** cpp_pkg.sv ***
// constants, types and the contract list for the charger power path block
// Contract
// - strap reading sets default cell count, frequency and primary adapter limit
// - secondary adapter limit resets to 1.5A whatever the strap says
// - sixteen strap bands decode into cell, frequency and limit groups
// - ceiling and floor voltage defaults follow the decoded cell count
// - host may override strap frequency through a three-bit field
// - strap test current and sample happen before the adapter gate closes
// - battery power-up skips strap measurement unless power monitor enabled with battery above 5.8V
// - battery-only: each power monitor enable above 5.8V re-measures strap and restores cell, frequency and primary limit defaults
// - every adapter insertion reloads primary limit, measuring only when no reading
// - power monitor off resets ceiling and floor; on keeps them
// - current settings are one milliamp per count
// - diode emulation stretches short low-side on-time to a minimum
// - battery above 2.4V, adapter below 3.2V: battery-only, battery gate on
// - battery-only allows current monitor; power monitor only above 5.8V
// - adapter above 3.2V closes adapter gate; bias ok starts converter
// - charge only with nonzero charge setting and battery present
// - host command enters learn mode
// - learn entry delays battery gate until bus decays to battery
// - learn keeps both gates on and converter off
// - learn exits on command, enabled floor trip, or battery-absent rising
// - learn exit restarts switching at once
// - adapter debounce 1.3s or 150ms; first insertion always 150ms
package cpp_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned NS_PER_CLK = 1_000_000_000 / CLK_HZ;
  // settle time for the strap pin before sampling, least time
  localparam int unsigned STRAP_SETTLE_NS = 40_000;
  localparam int unsigned STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + NS_PER_CLK - 1) / NS_PER_CLK;
  // minimum low-side on-time in diode emulation, least time
  localparam int unsigned DE_MIN_ON_NS = 300;
  localparam int unsigned DE_MIN_ON_CYC = (DE_MIN_ON_NS + NS_PER_CLK - 1) / NS_PER_CLK;
  localparam int unsigned DEB_LONG_MS = 1300;
  localparam int unsigned DEB_SHORT_MS = 150;
  localparam int unsigned DEB_LONG_CYC = DEB_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned DEB_SHORT_CYC = DEB_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned DEB_W = 24;
  localparam int unsigned SET_W = 9;
  localparam int unsigned DE_W = 4;
  localparam int unsigned SYNC_N = 6;
  // register widths and values, currents in mA, voltages in mV
  localparam int unsigned REG_W = 16;
  localparam logic [REG_W-1:0] LIMIT_100MA = 16'h0064;
  localparam logic [REG_W-1:0] LIMIT_476MA = 16'h01DC;
  localparam logic [REG_W-1:0] LIMIT_1500MA = 16'h05DC;
  localparam logic [REG_W-1:0] CEIL_1CELL = 16'h1068;
  localparam logic [REG_W-1:0] CEIL_2CELL = 16'h20D0;
  localparam logic [REG_W-1:0] CEIL_3CELL = 16'h3138;
  localparam logic [REG_W-1:0] FLOOR_1CELL = 16'h0BB8;
  localparam logic [REG_W-1:0] FLOOR_2CELL = 16'h1770;
  localparam logic [REG_W-1:0] FLOOR_3CELL = 16'h2328;
  localparam logic [2:0] FREQ_733K = 3'h3;
  localparam logic [2:0] FREQ_1M = 3'h1;
  localparam logic [3:0] BAND_2CELL = 4'h6;
  localparam logic [3:0] BAND_3CELL = 4'hB;
  typedef enum logic [1:0] {CELL_NONE, CELL_1, CELL_2, CELL_3} cpp_cell_t;
  typedef enum logic [2:0] {ST_OFF, ST_BATT, ST_DEBOUNCE, ST_STRAP, ST_ADAPTER, ST_LEARN_WAIT, ST_LEARN} cpp_state_t;
  // synchroniser lane assignment
  localparam int unsigned SY_BAT24 = 0;
  localparam int unsigned SY_ADP32 = 1;
  localparam int unsigned SY_BIAS = 2;
  localparam int unsigned SY_BAT58 = 3;
  localparam int unsigned SY_SYSBAT = 4;
  localparam int unsigned SY_FLOOR = 5;
endpackage

// *** cpp_power_path.sv ***
// power path sequencing, strap decode and default loading for the charger
`timescale 1ns/1ps
`default_nettype none
module cpp_power_path
  import cpp_pkg::*;
#(
  parameter int unsigned DEB_LONG = DEB_LONG_CYC,
  parameter int unsigned DEB_SHORT = DEB_SHORT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic bat_above_2v4_i,
  input wire logic adp_above_3v2_i,
  input wire logic bias_above_3v8_i,
  input wire logic bat_above_5v8_i,
  input wire logic sys_at_bat_i,
  input wire logic bat_below_floor_i,
  input wire logic battery_absent_input_i,
  input wire logic [3:0] strap_band_i,
  input wire logic platform_power_monitor_en_i,
  input wire logic battery_current_monitor_en_i,
  input wire logic learn_floor_exit_en_i,
  input wire logic long_debounce_i,
  input wire logic learn_enter_i,
  input wire logic learn_exit_i,
  input wire logic freq_wr_i,
  input wire logic [2:0] freq_wr_data_i,
  input wire logic lim1_wr_i,
  input wire logic lim2_wr_i,
  input wire logic ceiling_wr_i,
  input wire logic floor_wr_i,
  input wire logic [REG_W-1:0] wr_data_i,
  input wire logic [REG_W-1:0] charge_current_setting_i,
  input wire logic diode_emulation_i,
  input wire logic ls_on_req_i,
  output logic config_strap_pin_source_o,
  output logic strap_valid_o,
  output logic [1:0] cell_count_o,
  output logic [2:0] switching_freq_o,
  output logic [REG_W-1:0] adapter_limit_primary_o,
  output logic [REG_W-1:0] adapter_limit_secondary_o,
  output logic [REG_W-1:0] system_voltage_ceiling_o,
  output logic [REG_W-1:0] system_voltage_floor_o,
  output logic adapter_switch_gate_o,
  output logic battery_switch_gate_o,
  output logic converter_en_o,
  output logic charge_en_o,
  output logic battery_only_o,
  output logic learn_mode_o,
  output logic platform_power_monitor_on_o,
  output logic battery_current_monitor_on_o,
  output logic ls_gate_o
);

  function automatic logic [1:0] band_cells(input logic [3:0] b);
    band_cells = (b < BAND_2CELL) ? CELL_1 : (b < BAND_3CELL) ? CELL_2 : CELL_3;
  endfunction

  function automatic logic [2:0] band_freq(input logic [3:0] b);
    case (b)
      4'h3, 4'h4, 4'h5, 4'h9, 4'hA, 4'hE, 4'hF: band_freq = FREQ_1M;
      default: band_freq = FREQ_733K;
    endcase
  endfunction

  function automatic logic [REG_W-1:0] band_limit(input logic [3:0] b);
    case (b)
      4'h0, 4'h5, 4'h6, 4'hB: band_limit = LIMIT_100MA;
      4'h1, 4'h3, 4'h7, 4'h9, 4'hC, 4'hE: band_limit = LIMIT_476MA;
      default: band_limit = LIMIT_1500MA;
    endcase
  endfunction

  function automatic logic [REG_W-1:0] cell_ceiling(input logic [1:0] c);
    cell_ceiling = (c == CELL_3) ? CEIL_3CELL : (c == CELL_2) ? CEIL_2CELL : CEIL_1CELL;
  endfunction

  function automatic logic [REG_W-1:0] cell_floor(input logic [1:0] c);
    cell_floor = (c == CELL_3) ? FLOOR_3CELL : (c == CELL_2) ? FLOOR_2CELL : FLOOR_1CELL;
  endfunction

  // two-flop synchronisers for analog comparator flags and the strap band
  logic [SYNC_N-1:0] flag_raw;
  logic [SYNC_N-1:0] meta_q;
  logic [SYNC_N-1:0] flag_q;
  logic [3:0] band_meta_q;
  logic [3:0] band_q;
  logic absent_meta_q;
  logic absent_q;
  logic absent_prev_q;
  assign flag_raw = {bat_below_floor_i, sys_at_bat_i, bat_above_5v8_i, bias_above_3v8_i, adp_above_3v2_i,
                     bat_above_2v4_i};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta_q[gi] <= 1'b0;
          flag_q[gi] <= 1'b0;
        end else if (ce_i) begin
          meta_q[gi] <= flag_raw[gi];
          flag_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      band_meta_q <= 4'h0;
      band_q <= 4'h0;
      absent_meta_q <= 1'b0;
      absent_q <= 1'b0;
      absent_prev_q <= 1'b0;
    end else if (ce_i) begin
      band_meta_q <= strap_band_i;
      band_q <= band_meta_q;
      absent_meta_q <= battery_absent_input_i;
      absent_q <= absent_meta_q;
      absent_prev_q <= absent_q;
    end
  end

  wire bat_ok = flag_q[SY_BAT24];
  wire adp_ok = flag_q[SY_ADP32];
  wire bias_ok = flag_q[SY_BIAS];
  wire bat_hi = flag_q[SY_BAT58];
  wire sys_dec = flag_q[SY_SYSBAT];
  wire floor_trip = flag_q[SY_FLOOR];
  wire absent_rise = absent_q && !absent_prev_q;

  cpp_state_t state_q;
  cpp_state_t state_d;
  logic [DEB_W-1:0] deb_q;
  logic first_ins_q;
  logic [SET_W-1:0] meas_q;
  logic meas_busy_q;
  logic [3:0] band_store_q;
  logic valid_q;
  logic platform_power_monitor_prev_q;
  logic [DE_W-1:0] de_q;
  logic ls_prev_q;

  wire meas_done = meas_busy_q && (meas_q == SET_W'(STRAP_SETTLE_CYC - 1));
  wire platform_power_monitor_rise = platform_power_monitor_en_i && !platform_power_monitor_prev_q;
  wire deb_done = (state_q == ST_DEBOUNCE) && (deb_q == '0);
  wire batt_meas = (state_q == ST_BATT) && platform_power_monitor_rise && bat_hi;
  wire strap_meas = deb_done && !valid_q;
  wire meas_start = (batt_meas || strap_meas) && !meas_busy_q;
  wire learn_exit = learn_exit_i || (learn_floor_exit_en_i && floor_trip) || absent_rise;
  wire [3:0] load_band = meas_done ? band_q : band_store_q;
  wire lim1_load = meas_done || (deb_done && valid_q);
  wire vreg_load = meas_done && !platform_power_monitor_en_i;
  wire deb_first = !first_ins_q || !long_debounce_i;
  wire [DEB_W-1:0] deb_start = deb_first ? DEB_W'(DEB_SHORT - 1) : DEB_W'(DEB_LONG - 1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF, ST_BATT: begin
        if (adp_ok) begin
          state_d = ST_DEBOUNCE;
        end else if (bat_ok) begin
          state_d = (state_q == ST_BATT && learn_enter_i) ? ST_LEARN_WAIT : ST_BATT;
        end else begin
          state_d = ST_OFF;
        end
      end
      ST_DEBOUNCE: begin
        if (!adp_ok) begin
          state_d = ST_OFF;
        end else if (deb_done) begin
          state_d = valid_q ? ST_ADAPTER : ST_STRAP;
        end
      end
      ST_STRAP: begin
        if (meas_done) begin
          state_d = ST_ADAPTER;
        end
      end
      ST_ADAPTER: begin
        if (!adp_ok) begin
          state_d = ST_OFF;
        end else if (learn_enter_i) begin
          state_d = ST_LEARN_WAIT;
        end
      end
      ST_LEARN_WAIT, ST_LEARN: begin
        if (learn_exit) begin
          state_d = adp_ok ? ST_ADAPTER : ST_OFF;
        end else if (sys_dec) begin
          state_d = ST_LEARN;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_OFF;
      deb_q <= '0;
      first_ins_q <= 1'b0;
      platform_power_monitor_prev_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      platform_power_monitor_prev_q <= platform_power_monitor_en_i;
      if (state_q != ST_DEBOUNCE && state_d == ST_DEBOUNCE) begin
        deb_q <= deb_start;
      end else if (deb_q != '0) begin
        deb_q <= deb_q - 1'b1;
      end
      if (deb_done) begin
        first_ins_q <= 1'b1;
      end
    end
  end

  // strap measurement: source current, wait for settle, capture band
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meas_busy_q <= 1'b0;
      meas_q <= '0;
      band_store_q <= 4'h0;
      valid_q <= 1'b0;
    end else if (ce_i) begin
      if (meas_start) begin
        meas_busy_q <= 1'b1;
        meas_q <= '0;
      end else if (meas_done) begin
        meas_busy_q <= 1'b0;
        band_store_q <= band_q;
        valid_q <= 1'b1;
      end else if (meas_busy_q) begin
        meas_q <= meas_q + 1'b1;
      end
    end
  end

  // configuration registers; currents held at 1 mA per count
  logic [1:0] cells_q;
  logic [2:0] freq_q;
  logic [REG_W-1:0] lim1_q;
  logic [REG_W-1:0] lim2_q;
  logic [REG_W-1:0] ceil_q;
  logic [REG_W-1:0] floor_q;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cells_q <= CELL_NONE;
      freq_q <= FREQ_733K;
      lim1_q <= LIMIT_100MA;
      lim2_q <= LIMIT_1500MA;
      ceil_q <= CEIL_1CELL;
      floor_q <= FLOOR_1CELL;
    end else if (ce_i) begin
      if (meas_done) begin
        cells_q <= band_cells(band_q);
      end
      if (freq_wr_i) begin
        freq_q <= freq_wr_data_i;
      end else if (meas_done) begin
        freq_q <= band_freq(band_q);
      end
      if (lim1_wr_i) begin
        lim1_q <= wr_data_i;
      end else if (lim1_load) begin
        lim1_q <= band_limit(load_band);
      end
      if (lim2_wr_i) begin
        lim2_q <= wr_data_i;
      end
      if (vreg_load) begin
        ceil_q <= cell_ceiling(band_cells(band_q));
        floor_q <= cell_floor(band_cells(band_q));
      end else begin
        if (ceiling_wr_i) begin
          ceil_q <= wr_data_i;
        end
        if (floor_wr_i) begin
          floor_q <= wr_data_i;
        end
      end
    end
  end

  // diode emulation: hold the low-side gate for the minimum on-time
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      de_q <= '0;
      ls_prev_q <= 1'b0;
    end else if (ce_i) begin
      ls_prev_q <= ls_on_req_i;
      if (diode_emulation_i && ls_on_req_i && !ls_prev_q) begin
        de_q <= DE_W'(DE_MIN_ON_CYC - 1);
      end else if (de_q != '0) begin
        de_q <= de_q - 1'b1;
      end
    end
  end

  wire in_learn = (state_q == ST_LEARN_WAIT) || (state_q == ST_LEARN);
  assign ls_gate_o = ls_on_req_i || (de_q != '0);
  assign config_strap_pin_source_o = meas_busy_q;
  assign strap_valid_o = valid_q;
  assign cell_count_o = cells_q;
  assign switching_freq_o = freq_q;
  assign adapter_limit_primary_o = lim1_q;
  assign adapter_limit_secondary_o = lim2_q;
  assign system_voltage_ceiling_o = ceil_q;
  assign system_voltage_floor_o = floor_q;
  assign battery_only_o = (state_q == ST_BATT);
  assign learn_mode_o = in_learn;
  assign adapter_switch_gate_o = (state_q == ST_ADAPTER) || in_learn;
  assign battery_switch_gate_o = battery_only_o || (state_q == ST_LEARN) || charge_en_o;
  assign converter_en_o = (state_q == ST_ADAPTER) && bias_ok;
  assign charge_en_o = converter_en_o && (charge_current_setting_i != '0) && !absent_q;
  assign battery_current_monitor_on_o = battery_current_monitor_en_i;
  assign platform_power_monitor_on_o = platform_power_monitor_en_i && (!battery_only_o || bat_hi);

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_learn_entered;
    ce_i && learn_enter_i && state_q == ST_ADAPTER && adp_ok;
  endsequence
  sequence s_strap_start;
    ce_i && meas_start;
  endsequence

  a_strap_gate_off: assert property (config_strap_pin_source_o |-> !adapter_switch_gate_o)
    else $error("adapter gate closed while strap measured");
  a_strap_settle: assert property (s_strap_start |=> config_strap_pin_source_o[*4])
    else $error("strap source dropped early");
  a_learn_gates: assert property (s_learn_entered |=> learn_mode_o && !converter_en_o && adapter_switch_gate_o)
    else $error("learn entry did not stop converter");
  a_learn_battery_switch_gate_wait: assert property (state_q == ST_LEARN_WAIT |-> !battery_switch_gate_o)
    else $error("battery gate on before bus decayed");
  a_learn_exit_run: assert property (ce_i && in_learn && learn_exit_i && adp_ok |=> state_q == ST_ADAPTER)
    else $error("learn exit did not resume switching");
  a_charge_qual: assert property (charge_en_o |-> charge_current_setting_i != '0 && !absent_q)
    else $error("charging without setting or battery");
  a_batt_gate_on: assert property (battery_only_o |-> battery_switch_gate_o && !adapter_switch_gate_o)
    else $error("battery-only without battery gate");
  a_platform_power_monitor_allow: assert property (platform_power_monitor_on_o && battery_only_o |-> bat_hi)
    else $error("power monitor on at low battery");
  a_freq_override: assert property (ce_i && freq_wr_i |=> switching_freq_o == $past(freq_wr_data_i))
    else $error("frequency write not applied");
  a_valid_sticky: assert property (strap_valid_o |=> strap_valid_o)
    else $error("strap valid flag lost");
  a_de_min_on: assert property (ce_i && diode_emulation_i && ls_on_req_i && !ls_prev_q |=> ls_gate_o[*2])
    else $error("low-side on-time below minimum");
  a_vreg_keep: assert property (ce_i && platform_power_monitor_en_i && !ceiling_wr_i |=>
    $stable(system_voltage_ceiling_o))
    else $error("ceiling changed while power monitor on");

endmodule // cpp_power_path
`default_nettype wire

// *** cpp_power_path_bench.sv ***
// self-checking testbench of the charger power path
`timescale 1ns/1ps
`default_nettype none
module cpp_power_path_bench;
  import cpp_pkg::*;
  logic clk = 0, rst_n = 0, absent = 0, ppm_en = 0, bcm_en = 0, fl_en = 0, long_deb = 0;
  logic l_in = 0, l_out = 0, f_wr = 0, w1 = 0, w2 = 0, wc = 0, wf = 0, de = 0, ls_req = 0;
  logic [2:0] f_data = 3'h0;
  logic [3:0] band = 4'h0;
  logic [15:0] wdata = 16'h0000, chg_set = 16'h0000, bat = 16'h0000, adp = 16'h0000;
  logic b24, a32, b38, b58, s_at_b, b_fl, src, valid, agate, battery_switch_gate, conv, chg, bonly, learn, ppm_on, bcm_on, lsg;
  logic [1:0] cells;
  logic [2:0] freq;
  logic [15:0] lim1, lim2, ceil, flr;
  int n_mismatch = 0, n_checks = 0, k, b, e;
  logic [15:0] lims [5] = '{LIMIT_100MA, LIMIT_476MA, LIMIT_1500MA, LIMIT_476MA, LIMIT_1500MA};

  always #50 clk = ~clk;

  cpp_analog_model u_cpp_analog_model (.ref_clk_i(clk), .bat_mv_i(bat), .adp_mv_i(adp), .floor_i(flr),
    .learn_mode_i(learn), .bat_above_2v4_o(b24), .adp_above_3v2_o(a32), .bias_above_3v8_o(b38),
    .bat_above_5v8_o(b58), .bat_below_floor_o(b_fl), .sys_at_bat_o(s_at_b));

  cpp_power_path #(.DEB_LONG(40), .DEB_SHORT(10)) u_cpp_power_path (.ref_clk_i(clk), .reset_n_i(rst_n),
    .ce_i(1'b1), .bat_above_2v4_i(b24), .adp_above_3v2_i(a32), .bias_above_3v8_i(b38), .bat_above_5v8_i(b58),
    .sys_at_bat_i(s_at_b), .bat_below_floor_i(b_fl), .battery_absent_input_i(absent), .strap_band_i(band),
    .platform_power_monitor_en_i(ppm_en), .battery_current_monitor_en_i(bcm_en),
    .learn_floor_exit_en_i(fl_en), .long_debounce_i(long_deb), .learn_enter_i(l_in), .learn_exit_i(l_out),
    .freq_wr_i(f_wr), .freq_wr_data_i(f_data), .lim1_wr_i(w1), .lim2_wr_i(w2), .ceiling_wr_i(wc),
    .floor_wr_i(wf), .wr_data_i(wdata), .charge_current_setting_i(chg_set), .diode_emulation_i(de),
    .ls_on_req_i(ls_req), .config_strap_pin_source_o(src), .strap_valid_o(valid), .cell_count_o(cells),
    .switching_freq_o(freq), .adapter_limit_primary_o(lim1), .adapter_limit_secondary_o(lim2),
    .system_voltage_ceiling_o(ceil), .system_voltage_floor_o(flr), .adapter_switch_gate_o(agate),
    .battery_switch_gate_o(battery_switch_gate), .converter_en_o(conv), .charge_en_o(chg), .battery_only_o(bonly),
    .learn_mode_o(learn), .platform_power_monitor_on_o(ppm_on), .battery_current_monitor_on_o(bcm_on),
    .ls_gate_o(lsg));

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    tick(5);
    rst_n <= 1'b1;
    tick(1);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    do_reset();
    @(negedge clk);
    chk_val(lim2, LIMIT_1500MA);
    chk_val(lim1, LIMIT_100MA);
    chk_bit(valid, 1'b0);
    chk_val(ceil, CEIL_1CELL);
    $display("test reset done");
    long_deb <= 1'b1;
    for (b = 0; b < 16; b++) begin
      do_reset();
      band <= b[3:0];
      adp <= 16'h4E20;
      for (k = 0; k < 40 && src !== 1'b1; k++) @(negedge clk);
      chk_bit(k < 20, 1'b1);
      chk_bit(agate, 1'b0);
      for (k = 0; k < 600 && agate !== 1'b1; k++) @(negedge clk);
      chk_bit(valid, 1'b1);
      chk_val(cells, (b < 6) ? 2'h1 : (b < 11) ? 2'h2 : 2'h3);
      e = (b < 6) ? b : (b - 6) % 5;
      chk_val(freq, (e < 3) ? FREQ_733K : FREQ_1M);
      chk_val(lim1, (b == 5) ? LIMIT_100MA : lims[e]);
      chk_val(ceil, (b < 6) ? CEIL_1CELL : (b < 11) ? CEIL_2CELL : CEIL_3CELL);
      chk_val(flr, (b < 6) ? FLOOR_1CELL : (b < 11) ? FLOOR_2CELL : FLOOR_3CELL);
      chk_val(lim2, LIMIT_1500MA);
    end
    $display("test strap decode done");
    @(posedge clk);
    f_wr <= 1'b1;
    f_data <= FREQ_733K;
    tick(1);
    f_wr <= 1'b0;
    f_data <= FREQ_1M;
    tick(1);
    chk_val(freq, FREQ_733K);
    chk_bit(conv, 1'b1);
    chk_bit(chg, 1'b0);
    chg_set <= 16'h0200;
    tick(1);
    @(negedge clk);
    chk_bit(chg, 1'b1);
    @(posedge clk);
    absent <= 1'b1;
    tick(4);
    chk_bit(chg, 1'b0);
    absent <= 1'b0;
    bat <= 16'h2EE0;
    tick(4);
    $display("test adapter done");
    for (e = 0; e < 3; e++) begin
      l_in <= 1'b1;
      tick(1);
      l_in <= 1'b0;
      @(negedge clk);
      chk_bit(learn, 1'b1);
      chk_bit(battery_switch_gate, 1'b0);
      for (k = 0; k < 40 && battery_switch_gate !== 1'b1; k++) @(negedge clk);
      chk_bit(s_at_b & battery_switch_gate & agate & ~conv, 1'b1);
      tick(1);
      if (e == 0) l_out <= 1'b1;
      if (e == 1) fl_en <= 1'b1;
      if (e == 1) bat <= 16'h1F40;
      if (e == 2) absent <= 1'b1;
      tick(1);
      l_out <= 1'b0;
      for (k = 0; k < 10 && learn !== 1'b0; k++) @(negedge clk);
      chk_bit(k < 10, 1'b1);
      chk_bit(conv, 1'b1);
      @(posedge clk);
      fl_en <= 1'b0;
      bat <= 16'h2EE0;
      absent <= 1'b0;
      tick(5);
    end
    $display("test learn done");
    de <= 1'b1;
    ls_req <= 1'b1;
    repeat (DE_MIN_ON_CYC) begin
      @(negedge clk);
      chk_bit(lsg, 1'b1);
      @(posedge clk);
      ls_req <= 1'b0;
    end
    tick(6);
    chk_bit(lsg, 1'b0);
    $display("test diode emulation done");
    adp <= 16'h0000;
    w1 <= 1'b1;
    wdata <= 16'h0123;
    tick(1);
    w1 <= 1'b0;
    tick(10);
    chk_bit(agate, 1'b0);
    adp <= 16'h4E20;
    e = 0;
    for (k = 0; k < 80 && agate !== 1'b1; k++) begin
      @(negedge clk);
      e = e | src;
    end
    chk_bit(k >= 40, 1'b1);
    chk_bit(e[0], 1'b0);
    chk_val(lim1, LIMIT_1500MA);
    $display("test reinsertion done");
    @(posedge clk);
    adp <= 16'h0000;
    bat <= 16'h0E74;
    do_reset();
    bcm_en <= 1'b1;
    ppm_en <= 1'b1;
    tick(500);
    chk_bit(bonly & battery_switch_gate & bcm_on, 1'b1);
    chk_bit(ppm_on | valid, 1'b0);
    ppm_en <= 1'b0;
    bat <= 16'h1F40;
    band <= 4'h7;
    wc <= 1'b1;
    wdata <= 16'h2000;
    tick(1);
    wc <= 1'b0;
    tick(4);
    ppm_en <= 1'b1;
    for (k = 0; k < 600 && valid !== 1'b1; k++) @(negedge clk);
    tick(2);
    chk_val(cells, 2'h2);
    chk_val(lim1, LIMIT_476MA);
    chk_val(ceil, 16'h2000);
    chk_bit(ppm_on, 1'b1);
    $display("test battery only done");
    give_verdict();
  end
endmodule // cpp_power_path_bench
`default_nettype wire
